// ===== logic/reset_cause_pkg.sv
/*
 Constants for the reset cause recorder: register offsets, bit positions,
 reset values and the reset and interrupt vectors.
 Assumes a byte-wide register view over a 32-bit Wishbone bus.
*/
package reset_cause_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_FLAGS = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_BROWNOUT = 4'h8;
   localparam logic [3:0] OFS_WATCHDOG = 4'hc;
   localparam logic [3:0] OFS_IRQ_STAT = 4'h0;
   localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
   localparam logic [3:0] OFS_CONFIG = 4'h8;
   localparam logic [3:0] OFS_PC = 4'hc;
   localparam logic [1:0] BANK_MAIN = 2'h0;
   localparam logic [1:0] BANK_AUX = 2'h1;
   // ------------------------------------------------------------
   // Reset cause flag bits
   // ------------------------------------------------------------
   localparam int B_OVF = 7;
   localparam int B_UNF = 6;
   localparam int B_PIN = 3;
   localparam int B_INSTR = 2;
   localparam int B_POR = 1;
   localparam int B_BROWN = 0;
   localparam logic [7:0] FLAGS_IMPL = 8'hcf;
   localparam logic [7:0] FLAGS_POR = 8'h0c;
   // ------------------------------------------------------------
   // Core status bits, brown-out and watchdog control values
   // ------------------------------------------------------------
   localparam int B_WDT_EXP = 4;
   localparam int B_SLEPT = 3;
   localparam logic [7:0] STATUS_IMPL = 8'h1f;
   localparam logic [7:0] STATUS_POR = 8'h18;
   localparam logic [7:0] STATUS_RW = 8'h07;
   localparam logic [7:0] BROWNOUT_IMPL = 8'h81;
   localparam logic [7:0] BROWNOUT_POR = 8'h80;
   localparam logic [7:0] WATCHDOG_IMPL = 8'h3f;
   localparam logic [7:0] WATCHDOG_POR = 8'h00;
   // ------------------------------------------------------------
   // Vectors and event bits of the interrupt status register
   // ------------------------------------------------------------
   localparam logic [14:0] VEC_RESET = 15'h0000;
   localparam logic [14:0] VEC_IRQ = 15'h0004;
   localparam logic [14:0] PC_STEP = 15'h0001;
   localparam int N_EVT = 8;
   localparam int E_POR = 0;
   localparam int E_BROWN = 1;
   localparam int E_PIN = 2;
   localparam int E_WDT = 3;
   localparam int E_INSTR = 4;
   localparam int E_OVF = 5;
   localparam int E_UNF = 6;
   localparam int E_WAKE = 7;
   typedef enum logic [1:0] {ACT_NONE, ACT_RESTART, ACT_RESUME} act_t;
endpackage

// ===== logic/reset_cause_recorder.sv
/*
 Reset cause recorder: keeps the reset cause flags and the timeout and
 power-down bits of the core status, and chooses the restart address.
 Assumes event inputs are one-cycle pulses synchronous to clk_i and that
 firmware drives a classic Wishbone master.
*/
// What this block does
// - Stack overflow sets bit 7, firmware clears
// - Stack underflow sets bit 6, firmware clears
// - Bits 5 and 4 read zero, ignore writes
// - Pin reset clears bit 3; firmware sets
// - Reset instruction clears bit 2; firmware rearms
// - Power-on clears bit 1; firmware sets
// - Power-on or brown-out clears bit 0
// - Power-on loads vector zero and reset values
// - Watchdog clears timeout; in sleep resumes
// - Interrupt wake clears power-down, may vector
// - Pin reset awake clears only pin flag
// - Pin reset asleep sets timeout, clears power-down
// - Reset instruction restarts, clears its flag only
// - Overflow reset restarts with overflow flag set
// - Underflow reset restarts with underflow flag set
// - Unimplemented bits always read zero
// - Stack faults reset only when option set
// - Programming mode exit acts as power-on

// Limitations
// - Event inputs must be single-cycle pulses; a held level
//   applies its update again on every cycle.
// - pc_i must hold the address of the sleep instruction when a
//   wake event arrives, since the resume target is pc_i plus one.
// - Every mapped word answers in one cycle; unused offsets inside
//   the two banks read as zero and ignore writes.
// - rst_i restores reset values but is not a power-on event by
//   itself; power_on_i has to be pulsed for that.
// - A write needs byte lane 0 selected to take effect.
`timescale 1ns/1ps
module reset_cause_recorder
   import reset_cause_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic power_on_i,
   input wire logic brownout_i,
   input wire logic prog_exit_i,
   input wire logic external_reset_pin_i,
   input wire logic wdt_timeout_i,
   input wire logic reset_instr_i,
   input wire logic stack_overflow_i,
   input wire logic stack_underflow_i,
   input wire logic irq_wake_i,
   input wire logic sleep_enter_i,
   input wire logic [14:0] pc_i,
   input wire logic borrdy_i,
   output logic [14:0] pc_load_o,
   output logic pc_load_valid_o,
   output logic irq_push_o,
   output logic core_reset_o,
   output logic irq_o
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] flags;
   logic [7:0] status;
   logic [7:0] brownout_control;
   logic [7:0] watchdog_control;
   logic [7:0] irq_stat;
   logic [7:0] irq_mask;
   logic stack_fault_reset_option;
   logic global_irq_enable;
   logic asleep;
   logic [7:0] next_flags;
   logic [7:0] next_status;
   logic [7:0] evt;
   act_t act;
   logic [14:0] act_pc;
   logic act_push;
   logic por_evt;
   logic brown_evt;
   logic ovf_rst;
   logic unf_rst;

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // A request is taken only while no answer is pending, so a
   // held strobe is answered once and then taken again.
   logic req;
   logic wr;
   logic hit;
   logic [1:0] bank;
   logic [3:0] ofs;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign bank = wb_adr_i[5:4];
   assign ofs = wb_adr_i[3:0];
   assign hit = (wb_adr_i[31:6] == 26'h0) &&
      (bank == BANK_MAIN || bank == BANK_AUX);
   assign wr = req && hit && wb_we_i && wb_sel_i[0];

   function automatic logic sel(input logic [1:0] b, input logic [3:0] o);
      sel = wr && bank == b && ofs == o;
   endfunction


   // ------------------------------------------------------------
   // Event classification
   // ------------------------------------------------------------
   // Programming exit is treated exactly as a power-on event, and a
   // brown-out in the same cycle as a power-on is absorbed by it.
   assign por_evt = power_on_i || prog_exit_i;
   assign brown_evt = brownout_i && !por_evt;
   assign ovf_rst = stack_overflow_i && stack_fault_reset_option;
   assign unf_rst = stack_underflow_i && stack_fault_reset_option;

   // ------------------------------------------------------------
   // Next flag and status values
   // ------------------------------------------------------------
   // Precedence, highest first: power-on or programming exit,
   // brown-out, pin reset, watchdog, interrupt wake, sleep entry.
   // Stack faults and the reset instruction touch only their own
   // flags, so they may combine with a pin reset or a watchdog.
   // A firmware write is applied first and then overwritten bit by
   // bit, so a hardware event in the same cycle always wins.
   always_comb begin
      next_flags = flags;
      next_status = status;
      if (sel(BANK_MAIN, OFS_FLAGS)) begin
         next_flags = wb_dat_i[7:0] & FLAGS_IMPL;
      end
      if (sel(BANK_MAIN, OFS_STATUS)) begin
         // Timeout and power-down stay read-only for firmware
         next_status = wb_dat_i[7:0] & STATUS_RW;
         next_status[B_WDT_EXP] = status[B_WDT_EXP];
         next_status[B_SLEPT] = status[B_SLEPT];
      end
      act = ACT_NONE;
      act_pc = VEC_RESET;
      act_push = 1'b0;
      if (por_evt) begin
         next_flags = FLAGS_POR;
         next_status = STATUS_POR;
         act = ACT_RESTART;
      end else if (brown_evt) begin
         // Brown-out keeps the power-on flag as it was
         next_flags = FLAGS_POR;
         next_flags[B_POR] = flags[B_POR];
         next_status[B_WDT_EXP] = 1'b1;
         next_status[B_SLEPT] = 1'b1;
         act = ACT_RESTART;
      end else begin
         if (stack_overflow_i) begin
            next_flags[B_OVF] = 1'b1;
         end
         if (stack_underflow_i) begin
            next_flags[B_UNF] = 1'b1;
         end
         if (ovf_rst || unf_rst) begin
            act = ACT_RESTART;
         end
         if (reset_instr_i) begin
            next_flags[B_INSTR] = 1'b0;
            act = ACT_RESTART;
         end
         if (external_reset_pin_i) begin
            next_flags[B_PIN] = 1'b0;
            if (asleep) begin
               next_status[B_WDT_EXP] = 1'b1;
               next_status[B_SLEPT] = 1'b0;
            end
            act = ACT_RESTART;
         end else if (wdt_timeout_i) begin
            next_status[B_WDT_EXP] = 1'b0;
            if (asleep) begin
               next_status[B_SLEPT] = 1'b0;
               act = ACT_RESUME;
               act_pc = 15'(pc_i + PC_STEP);
            end else begin
               act = ACT_RESTART;
            end
         end else if (irq_wake_i && asleep && act == ACT_NONE) begin
            next_status[B_SLEPT] = 1'b0;
            act = ACT_RESUME;
            act_pc = 15'(pc_i + PC_STEP);
            act_push = global_irq_enable;
         end else if (sleep_enter_i && act == ACT_NONE) begin
            next_status[B_WDT_EXP] = 1'b1;
            next_status[B_SLEPT] = 1'b0;
         end
      end
      next_flags = next_flags & FLAGS_IMPL;
      next_status = next_status & STATUS_IMPL;
   end

   // Event vector for the interrupt status register; a wake only
   // counts while the core is asleep.
   always_comb begin
      evt = '0;
      evt[E_POR] = por_evt;
      evt[E_BROWN] = brown_evt;
      evt[E_PIN] = external_reset_pin_i;
      evt[E_WDT] = wdt_timeout_i;
      evt[E_INSTR] = reset_instr_i;
      evt[E_OVF] = stack_overflow_i;
      evt[E_UNF] = stack_underflow_i;
      evt[E_WAKE] = irq_wake_i && asleep;
   end


   // ------------------------------------------------------------
   // Flag and status registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= FLAGS_POR;
         status <= STATUS_POR;
      end else begin
         flags <= next_flags;
         status <= next_status;
      end
   end

   // Sleep tracking: any event that restarts or resumes the core
   // ends sleep, so a later wake cannot act twice.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         asleep <= 1'b0;
      end else if (act != ACT_NONE || por_evt || brown_evt) begin
         asleep <= 1'b0;
      end else if (sleep_enter_i) begin
         asleep <= 1'b1;
      end
   end


   // ------------------------------------------------------------
   // Restart address and core control
   // ------------------------------------------------------------
   // All three outputs are one-cycle pulses one edge after the
   // event; the address outside a pulse is the reset vector.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_load_o <= VEC_RESET;
         pc_load_valid_o <= 1'b0;
         irq_push_o <= 1'b0;
         core_reset_o <= 1'b0;
      end else begin
         pc_load_valid_o <= act != ACT_NONE;
         pc_load_o <= act_pc;
         irq_push_o <= act_push;
         core_reset_o <= act == ACT_RESTART;
      end
   end


   // ------------------------------------------------------------
   // Configuration and peripheral control registers
   // ------------------------------------------------------------
   // The stack fault option comes up set, so stack faults restart
   // the core until firmware turns the option off.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         brownout_control <= BROWNOUT_POR;
         watchdog_control <= WATCHDOG_POR;
         stack_fault_reset_option <= 1'b1;
         global_irq_enable <= 1'b0;
         irq_mask <= '0;
      end else begin
         brownout_control[0] <= borrdy_i;
         if (sel(BANK_MAIN, OFS_BROWNOUT)) begin
            brownout_control[7] <= wb_dat_i[7];
         end
         if (sel(BANK_MAIN, OFS_WATCHDOG)) begin
            watchdog_control <= wb_dat_i[7:0] & WATCHDOG_IMPL;
         end
         if (sel(BANK_AUX, OFS_CONFIG)) begin
            stack_fault_reset_option <= wb_dat_i[0];
            global_irq_enable <= wb_dat_i[1];
         end
         if (sel(BANK_AUX, OFS_IRQ_MASK)) begin
            irq_mask <= wb_dat_i[7:0];
         end
      end
   end


   // ------------------------------------------------------------
   // Interrupt status: set wins over write-one-to-clear
   // ------------------------------------------------------------
   // One flop per event bit, so the set-wins rule is local to it
   logic irq_clr_wr;
   assign irq_clr_wr = sel(BANK_AUX, OFS_IRQ_STAT);
   for (genvar i = 0; i < N_EVT; i++) begin : g_irq
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            irq_stat[i] <= 1'b0;
         end else if (evt[i]) begin
            irq_stat[i] <= 1'b1;
         end else if (irq_clr_wr && wb_dat_i[i]) begin
            irq_stat[i] <= 1'b0;
         end
      end
   end

   // Level output, one cycle behind the status and mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end


   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   // Ack or err one cycle after the request is taken; read data
   // stands only with the ack and is zero otherwise; only the PC
   // word carries anything above the byte, in bits 14 to 8.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= req && hit;
         wb_err_o <= req && !hit;
         wb_dat_o <= '0;
         if (req && hit && !wb_we_i) begin
            case ({bank, ofs})
               {BANK_MAIN, OFS_FLAGS}: wb_dat_o[7:0] <= flags;
               {BANK_MAIN, OFS_STATUS}: wb_dat_o[7:0] <= status;
               {BANK_MAIN, OFS_BROWNOUT}: begin
                  wb_dat_o[7:0] <= brownout_control & BROWNOUT_IMPL;
               end
               {BANK_MAIN, OFS_WATCHDOG}: wb_dat_o[7:0] <= watchdog_control;
               {BANK_AUX, OFS_IRQ_STAT}: wb_dat_o[7:0] <= irq_stat;
               {BANK_AUX, OFS_IRQ_MASK}: wb_dat_o[7:0] <= irq_mask;
               {BANK_AUX, OFS_CONFIG}: begin
                  wb_dat_o[1:0] <= {global_irq_enable,
                     stack_fault_reset_option};
               end
               {BANK_AUX, OFS_PC}: wb_dat_o[14:0] <= pc_load_o;
               default: wb_dat_o <= '0;
            endcase
         end
      end
   end
endmodule

// ===== verification/reset_cause_asserts.sv
/*
 Port checker for the reset cause recorder.
 Assumes it is bound to the recorder and sees only its ports.
*/
`timescale 1ns/1ps
module reset_cause_asserts
   import reset_cause_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic power_on_i,
   input wire logic brownout_i,
   input wire logic prog_exit_i,
   input wire logic external_reset_pin_i,
   input wire logic wdt_timeout_i,
   input wire logic reset_instr_i,
   input wire logic stack_overflow_i,
   input wire logic stack_underflow_i,
   input wire logic irq_wake_i,
   input wire logic sleep_enter_i,
   input wire logic [14:0] pc_i,
   input wire logic [14:0] pc_load_o,
   input wire logic pc_load_valid_o,
   input wire logic irq_push_o,
   input wire logic core_reset_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire logic any_ev = power_on_i || brownout_i || prog_exit_i ||
      external_reset_pin_i || wdt_timeout_i || reset_instr_i ||
      stack_overflow_i || stack_underflow_i || irq_wake_i || sleep_enter_i;
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   bus_answer_a: assert property (req |=> wb_ack_o ^ wb_err_o)
      else $error("bus request not answered in one cycle");
   unmapped_err_a: assert property (req && wb_adr_i >= 32'h20 |=> wb_err_o)
      else $error("unmapped access not refused");
   upper_zero_a: assert property (wb_dat_o[31:8] == 24'h0)
      else $error("read data above the byte not zero");
   por_vector_a: assert property (power_on_i || prog_exit_i |=>
      pc_load_valid_o && core_reset_o && pc_load_o == VEC_RESET)
      else $error("power-on restart missing");
   restart_vec_a: assert property (core_reset_o |->
      pc_load_valid_o && pc_load_o == VEC_RESET)
      else $error("restart not at address zero");
   pin_restart_a: assert property (external_reset_pin_i |=> core_reset_o)
      else $error("pin reset did not restart");
   bor_restart_a: assert property (brownout_i |=> core_reset_o)
      else $error("brown-out did not restart");
   wdt_target_a: assert property (wdt_timeout_i |=> pc_load_valid_o &&
      (pc_load_o == VEC_RESET || pc_load_o == $past(pc_i) + PC_STEP))
      else $error("watchdog target address wrong");
   push_resume_a: assert property (irq_push_o |->
      pc_load_valid_o && !core_reset_o)
      else $error("push without resume");
   quiet_valid_a: assert property (!any_ev |=> !pc_load_valid_o)
      else $error("load without an event");
endmodule

// ===== verification/reset_source_model.sv
/*
 Model of the on-chip reset and wake sources.
 Assumes the bench calls pulse from one thread at a time.
*/
`timescale 1ns/1ps
module reset_source_model (
   input wire logic clk_i,
   output logic [9:0] evt_o
);
   initial evt_o = 10'h000;
   // One-cycle pulse on one source line
   task automatic pulse(input int k);
      @(posedge clk_i);
      evt_o <= 10'h001 << k;
      @(posedge clk_i);
      evt_o <= 10'h000;
   endtask
endmodule

// ===== verification/tb.sv
/*
 Self-checking bench for the reset cause recorder.
 Assumes the source model and the bound port checker.
*/
`timescale 1ns/1ps
module tb;
   import reset_cause_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [31:0] adr = 32'h0;
   logic [31:0] wdat = 32'h0;
   logic [14:0] pc = 15'h0000;
   logic [9:0] evt;
   logic [31:0] dat_o, rdat;
   logic [14:0] pcl;
   logic ack, err, berr, valid, push, crst, irq;
   int fails = 0;
   int tests_run = 0;
   int cnt = 0;
   initial forever #25 clk_i = ~clk_i;
   reset_source_model i_reset_source_model(.clk_i(clk_i), .evt_o(evt));
   reset_cause_recorder i_reset_cause_recorder(.clk_i(clk_i),
      .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .wb_err_o(err), .power_on_i(evt[0]),
      .brownout_i(evt[1]), .prog_exit_i(evt[2]),
      .external_reset_pin_i(evt[3]), .wdt_timeout_i(evt[4]),
      .reset_instr_i(evt[5]), .stack_overflow_i(evt[6]),
      .stack_underflow_i(evt[7]), .irq_wake_i(evt[8]),
      .sleep_enter_i(evt[9]), .pc_i(pc), .borrdy_i(cnt[4]),
      .pc_load_o(pcl), .pc_load_valid_o(valid), .irq_push_o(push),
      .core_reset_o(crst), .irq_o(irq));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         fails++;
      end
   endtask
   task automatic bus(input logic [31:0] a, d, input logic w);
      @(posedge clk_i);
      cyc <= 1'b1;
      adr <= a;
      wdat <= d;
      we <= w;
      do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
      rdat = dat_o;
      berr = err;
      cyc <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [31:0] a, m, e);
      bus(a, 32'h0, 1'b0);
      chk(n, e, rdat & m);
   endtask
   task automatic ev(input int k, input logic r, v, p, input logic [14:0] e);
      i_reset_source_model.pulse(k);
      @(negedge clk_i);
      chk("core_reset", r, crst);
      chk("irq_push", p, push);
      chk("valid", v, valid);
      if (v) begin
         chk("pc_load", e, pcl);
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_por;
      ev(0, 1, 1, 0, VEC_RESET);
      rdc("flags", 32'h00, 32'hffffffff, 32'h0c);
      rdc("status", 32'h04, 32'h18, 32'h18);
      bus(32'h00, 32'hff, 1'b1);
      rdc("flags", 32'h00, 32'hffffffff, 32'hcf);
      bus(32'h24, 32'h0, 1'b0);
      chk("err", 1'b1, berr);
      $display("t_por done");
   endtask
   task automatic t_bor_pin;
      ev(1, 1, 1, 0, VEC_RESET);
      rdc("flags", 32'h00, 32'hff, 32'h0e);
      bus(32'h00, 32'hff, 1'b1);
      ev(3, 1, 1, 0, VEC_RESET);
      rdc("flags", 32'h00, 32'hff, 32'hc7);
      chk("irq", 1'b0, irq);
      bus(32'h14, 32'h04, 1'b1);
      repeat (2) @(negedge clk_i);
      chk("irq", 1'b1, irq);
      bus(32'h10, 32'h04, 1'b1);
      repeat (2) @(negedge clk_i);
      chk("irq", 1'b0, irq);
      ev(5, 1, 1, 0, VEC_RESET);
      rdc("flags", 32'h00, 32'hff, 32'hc3);
      $display("t_bor_pin done");
   endtask
   task automatic t_stack;
      bus(32'h00, 32'h0f, 1'b1);
      ev(6, 1, 1, 0, VEC_RESET);
      rdc("flags", 32'h00, 32'hff, 32'h8f);
      bus(32'h18, 32'h0, 1'b1);
      ev(7, 0, 0, 0, VEC_RESET);
      rdc("flags", 32'h00, 32'hff, 32'hcf);
      bus(32'h00, 32'h0f, 1'b1);
      rdc("flags", 32'h00, 32'hff, 32'h0f);
      $display("t_stack done");
   endtask
   task automatic t_sleep;
      bus(32'h18, 32'h03, 1'b1);
      pc <= 15'h0100;
      ev(9, 0, 0, 0, VEC_RESET);
      ev(4, 0, 1, 0, 15'h0101);
      rdc("status", 32'h04, 32'h18, 32'h00);
      ev(9, 0, 0, 0, VEC_RESET);
      ev(8, 0, 1, 1, 15'h0101);
      rdc("status", 32'h04, 32'h18, 32'h10);
      ev(9, 0, 0, 0, VEC_RESET);
      ev(3, 1, 1, 0, VEC_RESET);
      rdc("status", 32'h04, 32'h18, 32'h10);
      ev(4, 1, 1, 0, VEC_RESET);
      rdc("status", 32'h04, 32'h10, 32'h00);
      bus(32'h00, 32'hff, 1'b1);
      ev(2, 1, 1, 0, VEC_RESET);
      rdc("flags", 32'h00, 32'hff, 32'h0c);
      $display("t_sleep done");
   endtask
   task automatic t_regs;
      bus(32'h0c, 32'hff, 1'b1);
      rdc("watchdog", 32'h0c, 32'hff, 32'h3f);
      bus(32'h08, 32'h00, 1'b1);
      rdc("brownout_en", 32'h08, 32'h80, 32'h00);
      bus(32'h18, 32'h01, 1'b1);
      ev(8, 0, 0, 0, VEC_RESET);
      ev(9, 0, 0, 0, VEC_RESET);
      ev(8, 0, 1, 0, 15'h0101);
      bus(32'h04, 32'hff, 1'b1);
      rdc("status", 32'h04, 32'hff, 32'h17);
      $display("t_regs done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cnt <= cnt + 1;
      if (cnt == 3000) begin
         fails++;
         final_report;
      end
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_por;
      t_bor_pin;
      t_stack;
      t_sleep;
      t_regs;
      final_report;
   end
endmodule
bind reset_cause_recorder reset_cause_asserts i_reset_cause_asserts(
   .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .power_on_i(power_on_i), .brownout_i(brownout_i),
   .prog_exit_i(prog_exit_i), .external_reset_pin_i(external_reset_pin_i),
   .wdt_timeout_i(wdt_timeout_i), .reset_instr_i(reset_instr_i),
   .stack_overflow_i(stack_overflow_i), .irq_wake_i(irq_wake_i),
   .stack_underflow_i(stack_underflow_i), .sleep_enter_i(sleep_enter_i),
   .pc_i(pc_i), .pc_load_o(pc_load_o), .pc_load_valid_o(pc_load_valid_o),
   .irq_push_o(irq_push_o), .core_reset_o(core_reset_o));
